//--- axi_lite_master.sv
// AXI4-Lite master model standing on the bridge's bus side
`timescale 1ns/1ns
module axi_lite_master
(
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  output logic hung
);
  // ==========================================================
  // transfers
  // stalls last up to two syncs, so the bound is generous
  localparam int LIM = 4000;

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, hung} = 6'h00;
    {awaddr, araddr, wstrb} = 20'h00000;
    wdata = 32'h00000000;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'h7;
    r = 2'bxx;
    for (k = 0; k < LIM; k++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (k == LIM)
      hung <= 1'b1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int k;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    {r, d} = 34'bx;
    for (k = 0; k < LIM; k++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        {r, d} = {rresp, rdata};
        rready <= 1'b0;
        break;
      end
    end
    if (k == LIM)
      hung <= 1'b1;
  endtask
endmodule

//--- sync_bridge.sv
// register synchronization bridge between bus clock and core clock
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module sync_bridge
  import sync_bridge_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic generic_core_clock,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic core_enable,
  output logic [31:0] core_value_a,
  output logic [31:0] core_value_b
);

  bridge_state_s s_reg;
  bridge_state_s s_next;

  // ==========================================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic int chan_of(input sync_kind_e k);
    case (k)
      K_SOFT_RESET_BIT: return CH_SOFT_RESET_BIT;
      K_EN: return CH_EN;
      K_A: return CH_A;
      K_B: return CH_B;
      default: return CH_CNT;
    endcase
  endfunction

  function automatic logic is_core(input logic [7:0] a);
    return (a == CTRL_OFF) || (a == CORE_A_OFF) || (a == CORE_B_OFF);
  endfunction

  // ==========================================================
  // next state
  logic tick;
  logic eng_done;
  logic eng_claim;
  logic cont_run;
  logic blocked;
  logic do_write;
  logic set_ready;
  logic set_err;
  logic new_sr;
  logic new_en;
  logic [NCH-1:0] done;
  logic [31:0] rd_val;
  logic rd_hold;
  sync_kind_e wkind;
  int wch;

  always_comb
  begin
    s_next = s_reg;
    done = '0;
    set_ready = 1'b0;
    set_err = 1'b0;
    eng_claim = 1'b0;
    blocked = 1'b0;
    do_write = 1'b0;
    new_sr = 1'b0;
    new_en = 1'b0;
    rd_val = WORD_ZERO;
    rd_hold = 1'b0;
    wkind = K_IDLE;
    wch = CH_A;
    // core clock is only sampled; edges seen after the second flop
    tick = s_reg.gsync[1] & ~s_reg.gprev;
    s_next.gsync = {s_reg.gsync[0], generic_core_clock};
    s_next.gprev = s_reg.gsync[1];
    s_next.awready = 1'b0;
    s_next.wready = 1'b0;
    s_next.arready = 1'b0;
    if (s_reg.bvalid && bready)
    begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.rvalid && rready)
    begin
      s_next.rvalid = 1'b0;
    end
    // core-domain state advances only on core clock edges
    if (tick && s_reg.core_en)
    begin
      s_next.counter = s_reg.counter + 32'h00000001;
    end

    // ==========================================================
    // shared engine: a stopped core clock freezes it
    // held cycle after the last edge keeps the delay above its floor
    eng_done = s_reg.active && (s_reg.cnt == SYNC_LAST);
    if (s_reg.active && tick && (s_reg.cnt != SYNC_LAST))
    begin
      s_next.cnt = s_reg.cnt + 3'h1;
    end
    if (eng_done)
    begin
      s_next.active = 1'b0;
      s_next.pending = 1'b0;
      if (s_reg.kind == K_ONE_SHOT_READ_REQ)
      begin
        if (s_reg.rr_addr == COUNT_OFF)
        begin
          done[CH_CNT] = 1'b1;
          s_next.snap_ok = 1'b1;
        end
      end
      else
      begin
        done[chan_of(s_reg.kind)] = 1'b1;
      end
      // enable and reset completions never raise ready
      if (s_reg.kind == K_A || s_reg.kind == K_B)
      begin
        set_ready = 1'b1;
      end
    end
    // restart without touching the pending flag
    if (!s_reg.variant && s_reg.cont && !s_reg.active)
    begin
      s_next.active = 1'b1;
      s_next.kind = K_ONE_SHOT_READ_REQ;
      s_next.cnt = 3'h0;
    end

    // ==========================================================
    // per-register engines run side by side
    for (int i = 0; i < NCH; i++)
    begin
      if (s_reg.busy[i] && (s_reg.pcnt[i] == SYNC_LAST))
      begin
        s_next.busy[i] = 1'b0;
        done[i] = 1'b1;
      end
      else if (s_reg.busy[i] && tick)
      begin
        s_next.pcnt[i] = s_reg.pcnt[i] + 3'h1;
      end
    end
    if (s_reg.variant && !s_reg.busy[CH_CNT] && (s_reg.counter != s_reg.snap))
    begin
      s_next.busy[CH_CNT] = 1'b1;
      s_next.pcnt[CH_CNT] = 3'h0;
    end
    if (s_reg.variant && (|s_reg.busy) && (s_next.busy == '0)
        && !done[CH_SOFT_RESET_BIT] && !done[CH_EN])
    begin
      set_ready = 1'b1;
    end

    // ==========================================================
    // completion effects in the core domain
    if (done[CH_EN])
    begin
      s_next.core_en = s_reg.enable;
    end
    if (done[CH_A])
    begin
      s_next.core_a_q = s_reg.core_a;
    end
    if (done[CH_B])
    begin
      s_next.core_b_q = s_reg.core_b;
    end
    if (done[CH_CNT])
    begin
      s_next.snap = s_reg.counter;
    end
    if (done[CH_SOFT_RESET_BIT])
    begin
      s_next.soft_reset_bit = 1'b0;
      s_next.enable = 1'b0;
      s_next.core_en = 1'b0;
      s_next.core_a = WORD_ZERO;
      s_next.core_b = WORD_ZERO;
      s_next.core_a_q = WORD_ZERO;
      s_next.core_b_q = WORD_ZERO;
      s_next.counter = WORD_ZERO;
      s_next.cont = 1'b0;
    end

    // ==========================================================
    // bus acceptance: one write and one read in flight
    if (awvalid && wvalid && !s_reg.wpend && !s_reg.bvalid
        && !s_reg.awready)
    begin
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
      s_next.wpend = 1'b1;
      s_next.waddr = {awaddr[7:2], 2'b00};
      s_next.wdata = wdata;
      s_next.wstrb = wstrb;
    end
    if (arvalid && !s_reg.rpend && !s_reg.rvalid && !s_reg.arready)
    begin
      s_next.arready = 1'b1;
      s_next.rpend = 1'b1;
      s_next.raddr = {araddr[7:2], 2'b00};
    end

    // ==========================================================
    // write execution
    if (s_reg.wpend && !s_reg.bvalid)
    begin
      cont_run = s_reg.active && s_reg.kind == K_ONE_SHOT_READ_REQ && s_reg.cont;
      if (!s_reg.variant && s_reg.active && !cont_run)
      begin
        blocked = is_core(s_reg.waddr) || (s_reg.waddr == ONE_SHOT_READ_REQ_OFF)
          || s_reg.kind == K_EN || s_reg.kind == K_SOFT_RESET_BIT;
      end
      do_write = !blocked;
    end
    else
    begin
      cont_run = 1'b0;
    end
    if (do_write)
    begin
      s_next.wpend = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      if (!s_reg.variant && is_core(s_reg.waddr))
      begin
        s_next.cont = 1'b0;
      end
      case (s_reg.waddr)
        CTRL_OFF:
        begin
          new_sr = s_reg.wstrb[0] & s_reg.wdata[SOFT_RESET_BIT_BIT];
          new_en = s_reg.wstrb[0] ? s_reg.wdata[ENABLE_BIT] : s_reg.enable;
          if (s_reg.variant)
          begin
            if ((new_sr && s_reg.busy[CH_SOFT_RESET_BIT])
                || (new_en != s_reg.enable && s_reg.busy[CH_EN]))
            begin
              set_err = 1'b1;
              s_next.bresp = RESP_SLVERR;
            end
            else
            begin
              if (new_sr)
              begin
                s_next.soft_reset_bit = 1'b1;
                s_next.busy[CH_SOFT_RESET_BIT] = 1'b1;
                s_next.pcnt[CH_SOFT_RESET_BIT] = 3'h0;
              end
              if (new_en != s_reg.enable)
              begin
                s_next.enable = new_en;
                s_next.busy[CH_EN] = 1'b1;
                s_next.pcnt[CH_EN] = 3'h0;
              end
            end
          end
          else
          begin
            s_next.enable = new_en;
            // writing zero to the reset bit leaves it alone
            if (new_sr)
            begin
              s_next.soft_reset_bit = 1'b1;
            end
            wkind = new_sr ? K_SOFT_RESET_BIT : K_EN;
          end
        end
        CORE_A_OFF, CORE_B_OFF:
        begin
          wch = (s_reg.waddr == CORE_A_OFF) ? CH_A : CH_B;
          if (s_reg.variant && s_reg.busy[wch])
          begin
            set_err = 1'b1;
            s_next.bresp = RESP_SLVERR;
          end
          else
          begin
            if (wch == CH_A)
            begin
              s_next.core_a = merge(s_reg.core_a, s_reg.wdata, s_reg.wstrb);
            end
            else
            begin
              s_next.core_b = merge(s_reg.core_b, s_reg.wdata, s_reg.wstrb);
            end
            if (s_reg.variant)
            begin
              s_next.busy[wch] = 1'b1;
              s_next.pcnt[wch] = 3'h0;
            end
            else
            begin
              wkind = (wch == CH_A) ? K_A : K_B;
            end
          end
        end
        STATUS_OFF:
        begin
          if (s_reg.wstrb[0])
          begin
            s_next.err = s_reg.err & ~s_reg.wdata[ERROR_BIT];
            s_next.ready_flag = s_reg.ready_flag & ~s_reg.wdata[READY_BIT];
          end
        end
        ONE_SHOT_READ_REQ_OFF:
        begin
          s_next.rr_addr = s_reg.wdata[7:0];
          s_next.cont = s_reg.wdata[CONT_BIT] & ~s_reg.variant;
          if (!s_reg.variant
              && (s_reg.wdata[ONESHOT_BIT] || s_reg.wdata[CONT_BIT]))
          begin
            wkind = K_ONE_SHOT_READ_REQ;
            s_next.snap_ok = 1'b0;
          end
        end
        MODE_OFF:
        begin
          s_next.variant = s_reg.wdata[0];
        end
        SCRATCH_OFF:
        begin
          s_next.scratch = merge(s_reg.scratch, s_reg.wdata, s_reg.wstrb);
        end
        BUSY_OFF, COUNT_OFF:
        begin
          s_next.bresp = RESP_OKAY;
        end
        default:
        begin
          s_next.bresp = RESP_SLVERR;
        end
      endcase
      if (wkind != K_IDLE)
      begin
        eng_claim = 1'b1;
        s_next.active = 1'b1;
        s_next.kind = wkind;
        s_next.cnt = 3'h0;
        s_next.target = s_reg.waddr;
        s_next.pending = 1'b1;
      end
    end

    // ==========================================================
    // read execution
    if (s_reg.rpend && !s_reg.rvalid)
    begin
      case (s_reg.raddr)
        CTRL_OFF: rd_val = {30'h00000000, s_reg.enable, s_reg.soft_reset_bit};
        STATUS_OFF: rd_val = {29'h00000000, s_reg.ready_flag, s_reg.err,
          (s_reg.variant ? (|s_reg.busy) : s_reg.pending)};
        ONE_SHOT_READ_REQ_OFF: rd_val = {16'h0000, 1'b0, s_reg.cont, 6'h00,
          s_reg.rr_addr};
        BUSY_OFF: rd_val = {27'h0000000, s_reg.busy};
        MODE_OFF: rd_val = {31'h00000000, s_reg.variant};
        CORE_A_OFF: rd_val = s_reg.core_a;
        CORE_B_OFF: rd_val = s_reg.core_b;
        COUNT_OFF: rd_val = s_reg.snap;
        SCRATCH_OFF: rd_val = s_reg.scratch;
        default: rd_val = WORD_ZERO;
      endcase
      if (!s_reg.variant && s_reg.raddr == COUNT_OFF && !s_reg.snap_ok)
      begin
        if (eng_done && s_reg.kind == K_CNT)
        begin
          rd_val = s_reg.counter;
        end
        else
        begin
          // a pending sync first, then a sync of its own
          rd_hold = 1'b1;
          if (!s_reg.active && !eng_claim)
          begin
            s_next.active = 1'b1;
            s_next.kind = K_CNT;
            s_next.cnt = 3'h0;
            s_next.target = COUNT_OFF;
          end
        end
      end
      // control reads back at once during enable and reset syncs
      else if (!s_reg.variant && s_reg.active
               && (s_reg.kind == K_A || s_reg.kind == K_B)
               && s_reg.raddr == s_reg.target)
      begin
        rd_hold = 1'b1;
      end
      if (!rd_hold)
      begin
        s_next.rpend = 1'b0;
        s_next.rvalid = 1'b1;
        s_next.rdata = rd_val;
        s_next.rresp = (s_reg.raddr > SCRATCH_OFF) ? RESP_SLVERR
          : RESP_OKAY;
      end
    end

    // hardware set wins over a same-cycle software clear
    if (set_ready)
    begin
      s_next.ready_flag = 1'b1;
    end
    if (set_err)
    begin
      s_next.err = 1'b1;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign awready = s_reg.awready;
  assign wready = s_reg.wready;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = s_reg.arready;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign core_enable = s_reg.core_en;
  assign core_value_a = s_reg.core_a_q;
  assign core_value_b = s_reg.core_b_q;

endmodule

//--- sync_bridge_assertions.sv
// port-level checks of the register sync bridge
`timescale 1ns/1ns
module sync_bridge_assertions
  import sync_bridge_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // handshakes
  property p_pair; awready |-> wready && awvalid && wvalid; endproperty
  a_pair: assert property (p_pair)
    else $error("write ready without a full request");
  property p_awp; awready |=> !awready; endproperty
  a_awp: assert property (p_awp)
    else $error("write ready longer than one cycle");
  property p_arp; arready |=> !arready; endproperty
  a_arp: assert property (p_arp)
    else $error("read ready longer than one cycle");
  property p_bfirst; awready |-> !bvalid; endproperty
  a_bfirst: assert property (p_bfirst)
    else $error("write answer in the taking cycle");
  property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write answer dropped early");
  property p_rhold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read answer dropped early");
  property p_bdone; bvalid && bready |=> !bvalid; endproperty
  a_bdone: assert property (p_bdone)
    else $error("write answer repeated");
  // bus-side reads never wait on a sync
  property p_busr;
    arready && araddr == SCRATCH_OFF |=> rvalid && rresp == RESP_OKAY;
  endproperty
  a_busr: assert property (p_busr)
    else $error("bus register read stalled");
  property p_badr;
    arready && araddr > 8'h23 |=>
      rvalid && rresp == RESP_SLVERR && rdata == WORD_ZERO;
  endproperty
  a_badr: assert property (p_badr)
    else $error("unmapped read answered wrongly");

  c_count: cover property (arready && araddr == COUNT_OFF);
  c_err: cover property (bvalid && bresp == RESP_SLVERR);
  c_core: cover property (awready && awaddr == CORE_A_OFF);
endmodule

bind sync_bridge sync_bridge_assertions u_chk
(
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
);

//--- sync_bridge_pkg.sv
// constants, types and state layout for the register sync bridge
package sync_bridge_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] ONE_SHOT_READ_REQ_OFF = 8'h08;
  localparam logic [7:0] BUSY_OFF = 8'h0C;
  localparam logic [7:0] MODE_OFF = 8'h10;
  localparam logic [7:0] CORE_A_OFF = 8'h14;
  localparam logic [7:0] CORE_B_OFF = 8'h18;
  localparam logic [7:0] COUNT_OFF = 8'h1C;
  localparam logic [7:0] SCRATCH_OFF = 8'h20;

  // ==========================================================
  // field positions
  localparam int SOFT_RESET_BIT_BIT = 0;
  localparam int ENABLE_BIT = 1;
  localparam int PENDING_BIT = 0;
  localparam int ERROR_BIT = 1;
  localparam int READY_BIT = 2;
  localparam int CONT_BIT = 14;
  localparam int ONESHOT_BIT = 15;

  // per-register busy channels
  localparam int NCH = 5;
  localparam int CH_SOFT_RESET_BIT = 0;
  localparam int CH_EN = 1;
  localparam int CH_A = 2;
  localparam int CH_B = 3;
  localparam int CH_CNT = 4;

  // ==========================================================
  // timing: sync completes one cycle after this many core-clock edges
  localparam int SYNC_GENERIC_CORE_CLOCK_EDGES = 6;
  localparam logic [2:0] SYNC_LAST = 3'(SYNC_GENERIC_CORE_CLOCK_EDGES);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  typedef enum logic [2:0] {
    K_IDLE = 3'b000,
    K_SOFT_RESET_BIT = 3'b001,
    K_EN = 3'b010,
    K_A = 3'b011,
    K_B = 3'b100,
    K_CNT = 3'b101,
    K_ONE_SHOT_READ_REQ = 3'b110
  } sync_kind_e;

  typedef struct packed {
    logic [1:0] gsync;
    logic gprev;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic wpend;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic rpend;
    logic [7:0] raddr;
    logic soft_reset_bit;
    logic enable;
    logic [31:0] core_a;
    logic [31:0] core_b;
    logic [31:0] scratch;
    logic variant;
    logic [7:0] rr_addr;
    logic cont;
    logic snap_ok;
    logic pending;
    logic err;
    logic ready_flag;
    logic core_en;
    logic [31:0] core_a_q;
    logic [31:0] core_b_q;
    logic [31:0] counter;
    logic [31:0] snap;
    sync_kind_e kind;
    logic active;
    logic [2:0] cnt;
    logic [7:0] target;
    logic [NCH-1:0] busy;
    logic [NCH-1:0][2:0] pcnt;
  } bridge_state_s;

endpackage

//--- sync_bridge_tb_top.sv
// self-checking bench for the register sync bridge
`timescale 1ns/1ns
`define CHK(a, e) \
  begin \
    checked++; \
    if ((a) !== (e)) \
      $display("[ERR] %0t got %h want %h", $time, (a), (e)); \
    if ((a) !== (e)) \
      n_errors++; \
  end
module sync_bridge_tb_top
  import sync_bridge_pkg::*;
;
  localparam time D_LO = 5 * 32 + 2 * 4;
  localparam time D_HI = 6 * 32 + 3 * 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic generic_core_clock = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, core_value_a, core_value_b, v, c;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, hung;
  logic arvalid, arready, rvalid, rready, core_enable;
  int n_errors = 0;
  int checked = 0;
  time t0;

  always #2 aclk = ~aclk;
  // core clock offset by 3 ns so its edges fall between bus clock edges
  initial #3 forever #16 generic_core_clock = ~generic_core_clock;

  sync_bridge u_dut (.aclk(aclk), .aresetn(aresetn),
    .generic_core_clock(generic_core_clock), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .core_enable(core_enable),
    .core_value_a(core_value_a), .core_value_b(core_value_b));

  axi_lite_master u_mst (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .hung(hung));

  // ==========================================================
  // helpers
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge hung)
  begin
    n_errors++;
    tally_and_finish();
  end

  task automatic wx(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] e);
    u_mst.wr(a, d, r);
    `CHK(r, e)
  endtask

  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int k;
    for (k = 0; k < 400; k++)
    begin
      u_mst.rd(a, v, r);
      if ((v & m) == 32'h00000000)
        break;
    end
    if (k == 400)
      n_errors++;
    if (k == 400)
      tally_and_finish();
  endtask

  // ==========================================================
  // scenarios
  task automatic s_bus;
    u_mst.rd(STATUS_OFF, v, r);
    `CHK(v, WORD_ZERO)
    wx(SCRATCH_OFF, 32'hA5C3_0F1E, RESP_OKAY);
    u_mst.rd(SCRATCH_OFF, v, r);
    `CHK(v, 32'hA5C3_0F1E)
    u_mst.rd(8'h40, v, r);
    `CHK({r, v}, {RESP_SLVERR, WORD_ZERO})
  endtask

  task automatic s_write;
    int k;
    t0 = $time;
    wx(CORE_A_OFF, 32'h1357_9BDF, RESP_OKAY);
    u_mst.rd(STATUS_OFF, v, r);
    `CHK(v[PENDING_BIT], 1'b1)
    u_mst.rd(SCRATCH_OFF, v, r);
    `CHK($time - t0 < 80, 1'b1)
    for (k = 0; k < 300 && core_value_a !== 32'h1357_9BDF; k++)
      @(negedge aclk);
    // taken two edges after t0, seen half a cycle after the update
    `CHK($time - t0 - 10 > D_LO && $time - t0 - 10 < D_HI, 1'b1)
    t0 = $time;
    wx(CORE_A_OFF, 32'h2468_ACE0, RESP_OKAY);
    wx(CORE_B_OFF, 32'h0F0F_F0F0, RESP_OKAY);
    `CHK($time - t0 > D_LO, 1'b1)
    wx(CORE_A_OFF, 32'h3C3C_C3C3, RESP_OKAY);
    u_mst.rd(CORE_A_OFF, v, r);
    `CHK(v, 32'h3C3C_C3C3)
    `CHK(core_value_a, 32'h3C3C_C3C3)
    `CHK(core_value_b, 32'h0F0F_F0F0)
  endtask

  task automatic s_enable;
    wx(STATUS_OFF, 32'h0000_0006, RESP_OKAY);
    wx(CTRL_OFF, 32'h0000_0002, RESP_OKAY);
    u_mst.rd(CTRL_OFF, v, r);
    `CHK(v, 32'h0000_0002)
    t0 = $time;
    wx(SCRATCH_OFF, 32'h0000_00AA, RESP_OKAY);
    `CHK($time - t0 > 100, 1'b1)
    `CHK(core_enable, 1'b1)
    u_mst.rd(STATUS_OFF, v, r);
    `CHK(v, WORD_ZERO)
  endtask

  task automatic s_count;
    t0 = $time;
    u_mst.rd(COUNT_OFF, v, r);
    `CHK($time - t0 > D_LO, 1'b1)
    wx(CORE_A_OFF, 32'h1111_2222, RESP_OKAY);
    t0 = $time;
    u_mst.rd(COUNT_OFF, v, r);
    `CHK($time - t0 > D_LO + 140, 1'b1)
    wx(ONE_SHOT_READ_REQ_OFF, {24'h0000_80, COUNT_OFF}, RESP_OKAY);
    u_mst.rd(STATUS_OFF, v, r);
    `CHK(v[PENDING_BIT], 1'b1)
    poll(STATUS_OFF, 32'h0000_0001);
    u_mst.rd(COUNT_OFF, c, r);
    t0 = $time;
    u_mst.rd(COUNT_OFF, v, r);
    `CHK({$time - t0 < 40, v}, {1'b1, c})
    wx(ONE_SHOT_READ_REQ_OFF, {24'h0000_40, COUNT_OFF}, RESP_OKAY);
    poll(STATUS_OFF, 32'h0000_0001);
    u_mst.rd(COUNT_OFF, c, r);
    repeat (64) @(posedge aclk);
    t0 = $time;
    u_mst.rd(COUNT_OFF, v, r);
    `CHK({$time - t0 < 40, v > c}, 2'h3)
    u_mst.rd(STATUS_OFF, v, r);
    `CHK(v[PENDING_BIT], 1'b0)
    wx(CORE_B_OFF, 32'h3333_4444, RESP_OKAY);
    poll(STATUS_OFF, 32'h0000_0001);
    u_mst.rd(ONE_SHOT_READ_REQ_OFF, v, r);
    `CHK(v[CONT_BIT], 1'b0)
    u_mst.rd(COUNT_OFF, c, r);
    repeat (64) @(posedge aclk);
    u_mst.rd(COUNT_OFF, v, r);
    `CHK(v, c)
  endtask

  task automatic s_soft_reset_bit;
    wx(CTRL_OFF, 32'h0000_0001, RESP_OKAY);
    u_mst.rd(CTRL_OFF, v, r);
    `CHK(v[SOFT_RESET_BIT_BIT], 1'b1)
    t0 = $time;
    wx(SCRATCH_OFF, 32'h0000_0055, RESP_OKAY);
    `CHK($time - t0 > 100, 1'b1)
    poll(CTRL_OFF, 32'h0000_0001);
    u_mst.rd(STATUS_OFF, v, r);
    `CHK(v[PENDING_BIT], 1'b0)
  endtask

  task automatic s_per_reg;
    wx(MODE_OFF, 32'h0000_0001, RESP_OKAY);
    wx(STATUS_OFF, 32'h0000_0006, RESP_OKAY);
    wx(CORE_A_OFF, 32'hAAAA_0001, RESP_OKAY);
    wx(CORE_A_OFF, 32'hAAAA_0002, RESP_SLVERR);
    wx(CORE_B_OFF, 32'hBBBB_0001, RESP_OKAY);
    u_mst.rd(BUSY_OFF, v, r);
    `CHK(v[CH_B:CH_A], 2'h3)
    u_mst.rd(STATUS_OFF, v, r);
    `CHK(v[ERROR_BIT], 1'b1)
    poll(BUSY_OFF, 32'h0000_001F);
    `CHK(core_value_a, 32'hAAAA_0001)
    `CHK(core_value_b, 32'hBBBB_0001)
    u_mst.rd(STATUS_OFF, v, r);
    `CHK(v[READY_BIT:PENDING_BIT], 3'h6)
    wx(CTRL_OFF, 32'h0000_0002, RESP_OKAY);
    u_mst.rd(BUSY_OFF, v, r);
    `CHK(v[CH_EN], 1'b1)
    poll(BUSY_OFF, 32'h0000_0002);
    `CHK(core_enable, 1'b1)
  endtask

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    s_bus();
    s_write();
    s_enable();
    s_count();
    s_soft_reset_bit();
    s_per_reg();
    tally_and_finish();
  end
endmodule
